// ==== rtl/vto_pkg.sv ====
// shared constants and types for the video output timing and overlay block
// assumes a single 125 MHz pixel clock; the register port is a plain strobe bus
package vto_pkg;
  localparam int CLK_MHZ = 125;
  localparam int NCHAN = 4;                 // 0 main, 1 black 1, 2 black 2, 3 bars
  localparam int NOVL = 2;                  // 0 on main, 1 on bars
  localparam int NCHARS = 18;
  localparam int LN_W = 12;
  localparam int PX_W = 13;
  localparam int HO_W = 14;
  localparam int VO_W = 12;
  // line periods in ns, and their length in clocks
  localparam int NTSC_LINE_NS = 63556;
  localparam int PAL_LINE_NS = 64000;
  localparam int NTSC_LINE_CYC = (NTSC_LINE_NS * CLK_MHZ) / 1000;
  localparam int PAL_LINE_CYC = (PAL_LINE_NS * CLK_MHZ) / 1000;
  // lines in one colour frame
  localparam int NTSC_CF_LINES = 1050;
  localparam int PAL_CF_LINES = 2500;
  // half-second blink interval
  localparam int HALF_SEC_MS = 500;
  localparam int HALF_SEC_CYC = HALF_SEC_MS * CLK_MHZ * 1000;
  // overlay geometry, format independent
  localparam int ACT_H_START = 1200;
  localparam int ACT_W_CYC = 6575;
  localparam int ACT_V_START = 21;
  localparam int ACT_V_LINES = 480;
  localparam int XMUL = (ACT_W_CYC * 256) / 100;
  localparam int YMUL = (ACT_V_LINES * 256) / 100;
  localparam int CHAR_SH = 4;
  localparam int CHAR_H = 16;
  localparam int PCT_MAX = 100;
  // register byte offsets
  localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_FMT_SIG = 8'h00;
  localparam logic [7:0] OFS_VOFF = 8'h04;
  localparam logic [7:0] OFS_HOFF = 8'h08;
  localparam logic [7:0] OFS_OVL_BASE = 8'h40;
  localparam logic [7:0] OFS_OVL_STRIDE = 8'h40;
  localparam logic [7:0] OFS_OVL_CTRL = 8'h00;
  localparam logic [7:0] OFS_OVL_XPOS = 8'h04;
  localparam logic [7:0] OFS_OVL_YPOS = 8'h08;
  localparam logic [7:0] OFS_OVL_TEXT = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'hC0;
  localparam logic [7:0] OFS_STAT = 8'hC4;
  localparam int CMD_ZERO_BIT = 0;
  localparam int CMD_SAVE_BIT = 1;
  localparam int CMD_CH_POS = 4;
  localparam int CMD_OVL_POS = 8;
  localparam int SIG_POS = 8;
  localparam logic [7:0] RST_CHAR = 8'h20;

  typedef enum logic [1:0] {FMT_NTSC = 2'h0, FMT_NTSC_NS = 2'h1, FMT_PAL = 2'h2} vto_fmt_e;
  typedef enum logic [4:0] {
    SIG_BB = 5'h00, SIG_BB_ALT = 5'h01, SIG_CSYNC = 5'h02, SIG_CBLANK = 5'h03, SIG_SUBC = 5'h04,
    SIG_HDRV = 5'h05, SIG_VDRV = 5'h06, SIG_FREF = 5'h07, SIG_PALP = 5'h08, SIG_BAR100 = 5'h09,
    SIG_BAR75 = 5'h0A, SIG_SMPTE = 5'h0B, SIG_BAR100R = 5'h0C, SIG_BAR75R = 5'h0D,
    SIG_FLAT40 = 5'h0E, SIG_OTHER1 = 5'h0F, SIG_OTHER2 = 5'h10
  } vto_sig_e;
  typedef enum logic [1:0] {OVL_OFF = 2'h0, OVL_ON = 2'h1, OVL_FAST = 2'h2, OVL_SLOW = 2'h3} vto_blink_e;

  typedef struct packed {
    vto_fmt_e fmt;
    vto_sig_e sig;
    logic signed [VO_W-1:0] voff;
    logic signed [HO_W-1:0] hoff;
  } vto_chan_s;
  typedef struct packed {
    logic [LN_W-1:0] line;
    logic [PX_W-1:0] pix;
    vto_fmt_e fmt;
    vto_sig_e sig;
  } vto_tim_s;
  typedef struct packed {
    logic show;
    logic [7:0] char_code;
  } vto_ovl_s;
endpackage

// ==== rtl/vto_top.sv ====
// per-output timing counters, format and signal selection, and text overlay
// assumes frame_rst_i is an asynchronous pin pulse and software drives the strobe port
`timescale 1ns/1ps
module vto_top import vto_pkg::*; #(
  parameter int HALF_SEC = HALF_SEC_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic frame_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output vto_tim_s [NCHAN-1:0] tim_o,
  output vto_ovl_s [NOVL-1:0] ovl_o,
  output logic [NOVL-1:0] ovl_save_o
);

  if (HALF_SEC < 2 || HALF_SEC > (1 << 26)) begin : g_chk
    $error("HALF_SEC out of range");
  end

  localparam int OVL_CH [NOVL] = '{0, 3};

  // line length in clocks for a format
  function automatic logic [PX_W-1:0] llen(input vto_fmt_e f);
    return (f == FMT_PAL) ? PX_W'(PAL_LINE_CYC) : PX_W'(NTSC_LINE_CYC);
  endfunction

  // colour frame length in lines for a format
  function automatic logic [LN_W-1:0] flen(input vto_fmt_e f);
    return (f == FMT_PAL) ? LN_W'(PAL_CF_LINES) : LN_W'(NTSC_CF_LINES);
  endfunction

  // which signals an output may carry; the main output takes any code
  function automatic logic sig_ok(input int ch, input vto_fmt_e f, input vto_sig_e s);
    logic pal;
    pal = (f == FMT_PAL);
    if (ch == 0) begin
      return 1'b1;
    end else if (ch == 3) begin
      return (s == SIG_BB) || (s == SIG_BB_ALT) || (s == SIG_BAR100) || (s == SIG_BAR75)
        || (s == SIG_FLAT40) || (s == SIG_OTHER1) || (s == SIG_OTHER2)
        || (!pal && s == SIG_SMPTE) || (pal && (s == SIG_BAR100R || s == SIG_BAR75R));
    end
    return (s <= SIG_FREF) || (pal && s == SIG_PALP);
  endfunction

  vto_chan_s [NCHAN-1:0] cfg_q;
  logic [LN_W-1:0] line_q [NCHAN];
  logic [PX_W-1:0] pix_q [NCHAN];
  logic [LN_W-1:0] pre_line [NCHAN];
  logic [PX_W-1:0] pre_pix [NCHAN];
  vto_blink_e ost_q [NOVL];
  logic [6:0] xpos_q [NOVL];
  logic [6:0] ypos_q [NOVL];
  logic [7:0] txt_q [NOVL][NCHARS];
  logic frs_meta_q, frs_q, frs_d1_q;
  logic frame_go;
  logic [25:0] blink_cnt_q;
  logic ph_fast_q, ph_slow_q;
  logic [31:0] rdata_q;
  logic [NOVL-1:0] save_q;
  vto_ovl_s [NOVL-1:0] ovl_q;
  logic [3:0] ch_hit;
  logic [1:0] ovl_hit;
  logic [5:0] ovl_ofs;
  logic cmd_hit;

  // frame reset pin through two flops, then edge detect on the settled copy
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      frs_meta_q <= 1'b0;
      frs_q <= 1'b0;
      frs_d1_q <= 1'b0;
    end else begin
      frs_meta_q <= frame_rst_i;
      frs_q <= frs_meta_q;
      frs_d1_q <= frs_q;
    end
  end
  assign frame_go = frs_q & ~frs_d1_q;

  // address decode shared by the write and read paths
  always_comb begin
    ch_hit = '0;
    ovl_hit = '0;
    ovl_ofs = '0;
    for (int c = 0; c < NCHAN; c++) begin
      ch_hit[c] = (addr_i[7:4] == 4'(c));
    end
    for (int o = 0; o < NOVL; o++) begin
      ovl_hit[o] = (addr_i[7:6] == 2'(o + 1));
    end
    ovl_ofs = addr_i[5:0];
    cmd_hit = wr_i && (addr_i == OFS_CMD);
  end

  // preload values: counters start at minus the offset, borrowing across lines
  always_comb begin
    logic signed [15:0] t, l, ll, fl, adj;
    t = '0;
    l = '0;
    ll = '0;
    fl = '0;
    adj = '0;
    for (int c = 0; c < NCHAN; c++) begin
      ll = $signed(16'(llen(cfg_q[c].fmt)));
      fl = $signed(16'(flen(cfg_q[c].fmt)));
      t = -16'(cfg_q[c].hoff);
      adj = 16'sh0000;
      if (t < 0) begin
        t = t + ll;
        adj = -16'sh0001;
      end else if (t >= ll) begin
        t = t - ll;
        adj = 16'sh0001;
      end
      l = -16'(cfg_q[c].voff) + adj;
      if (l < 0) begin
        l = l + fl;
      end else if (l >= fl) begin
        l = l - fl;
      end
      pre_line[c] = LN_W'(l);
      pre_pix[c] = PX_W'(t);
    end
  end

  // one line and pixel counter pair per output; >= keeps them sane after a format change
  always_ff @(posedge sys_clk_i) begin
    for (int c = 0; c < NCHAN; c++) begin
      if (reset_i) begin
        line_q[c] <= '0;
        pix_q[c] <= '0;
      end else if (frame_go) begin
        line_q[c] <= pre_line[c];
        pix_q[c] <= pre_pix[c];
      end else if (pix_q[c] >= llen(cfg_q[c].fmt) - PX_W'(1)) begin
        pix_q[c] <= '0;
        line_q[c] <= (line_q[c] >= flen(cfg_q[c].fmt) - LN_W'(1)) ? '0 : line_q[c] + LN_W'(1);
      end else begin
        pix_q[c] <= pix_q[c] + PX_W'(1);
      end
    end
  end

  // per-output configuration writes and the zero command
  always_ff @(posedge sys_clk_i) begin
    vto_fmt_e nf;
    vto_sig_e ns;
    logic signed [VO_W-1:0] wv;
    logic signed [HO_W-1:0] wh;
    logic signed [15:0] half, lmax;
    for (int c = 0; c < NCHAN; c++) begin
      nf = vto_fmt_e'(wdata_i[1:0]);
      ns = vto_sig_e'(wdata_i[SIG_POS+4:SIG_POS]);
      wv = $signed(wdata_i[VO_W-1:0]);
      wh = $signed(wdata_i[HO_W-1:0]);
      half = $signed(16'(flen(cfg_q[c].fmt) >> 1));
      lmax = $signed(16'(llen(cfg_q[c].fmt)));
      if (reset_i) begin
        cfg_q[c].fmt <= FMT_NTSC;
        cfg_q[c].sig <= (c == 1 || c == 2) ? SIG_BB : SIG_SMPTE;
        cfg_q[c].voff <= '0;
        cfg_q[c].hoff <= '0;
      end else if (cmd_hit && wdata_i[CMD_ZERO_BIT] && wdata_i[CMD_CH_POS+1:CMD_CH_POS] == 2'(c)) begin
        cfg_q[c].voff <= '0;
        cfg_q[c].hoff <= '0;
      end else if (wr_i && ch_hit[c]) begin
        if (addr_i[3:0] == OFS_FMT_SIG[3:0] && wdata_i[1:0] != 2'h3) begin
          cfg_q[c].fmt <= nf;
          if (sig_ok(c, nf, ns)) begin
            cfg_q[c].sig <= ns;
          end else if (!sig_ok(c, nf, cfg_q[c].sig)) begin
            cfg_q[c].sig <= SIG_BB;
          end
        end
        if (addr_i[3:0] == OFS_VOFF[3:0] && 16'(wv) <= half && 16'(wv) >= -half) begin
          cfg_q[c].voff <= wv;
        end
        if (addr_i[3:0] == OFS_HOFF[3:0] && 16'(wh) <= lmax && 16'(wh) >= -lmax) begin
          cfg_q[c].hoff <= wh;
        end
      end
    end
  end

  // overlay settings and text; out-of-range percentages are refused
  always_ff @(posedge sys_clk_i) begin
    for (int o = 0; o < NOVL; o++) begin
      if (reset_i) begin
        ost_q[o] <= OVL_OFF;
        xpos_q[o] <= '0;
        ypos_q[o] <= '0;
        for (int k = 0; k < NCHARS; k++) begin
          txt_q[o][k] <= RST_CHAR;
        end
      end else if (wr_i && ovl_hit[o]) begin
        if (ovl_ofs == OFS_OVL_CTRL[5:0]) begin
          ost_q[o] <= vto_blink_e'(wdata_i[1:0]);
        end
        if (ovl_ofs == OFS_OVL_XPOS[5:0] && wdata_i[6:0] <= 7'(PCT_MAX)) begin
          xpos_q[o] <= wdata_i[6:0];
        end
        if (ovl_ofs == OFS_OVL_YPOS[5:0] && wdata_i[6:0] <= 7'(PCT_MAX)) begin
          ypos_q[o] <= wdata_i[6:0];
        end
        for (int k = 0; k < NCHARS; k++) begin
          if (ovl_ofs == OFS_OVL_TEXT[5:0] + 6'(4 * (k / 4))) begin
            txt_q[o][k] <= wdata_i[8*(k%4) +: 8];
          end
        end
      end
    end
  end

  // save command: one-cycle pulse on ovl_save_o telling the equipment to store text and position
  always_ff @(posedge sys_clk_i) begin
    for (int o = 0; o < NOVL; o++) begin
      if (reset_i) begin
        save_q[o] <= 1'b0;
      end else begin
        save_q[o] <= cmd_hit && wdata_i[CMD_SAVE_BIT] && (wdata_i[CMD_OVL_POS] == 1'(o));
      end
    end
  end

  // half-second tick shared by both blink rates so they stay in step
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      blink_cnt_q <= '0;
      ph_fast_q <= 1'b1;
      ph_slow_q <= 1'b1;
    end else if (blink_cnt_q == 26'(HALF_SEC - 1)) begin
      blink_cnt_q <= '0;
      ph_fast_q <= ~ph_fast_q;
      if (!ph_fast_q) begin
        ph_slow_q <= ~ph_slow_q;
      end
    end else begin
      blink_cnt_q <= blink_cnt_q + 26'h0000001;
    end
  end

  // overlay beam test; lags the timing outputs by one clock
  always_ff @(posedge sys_clk_i) begin
    logic [PX_W-1:0] x0, dx;
    logic [LN_W-1:0] y0;
    logic vis, hit;
    logic [4:0] idx;
    for (int o = 0; o < NOVL; o++) begin
      x0 = PX_W'(ACT_H_START) + PX_W'((21'(xpos_q[o]) * 21'(XMUL)) >> 8);
      y0 = LN_W'(ACT_V_START) + LN_W'((17'(ypos_q[o]) * 17'(YMUL)) >> 8);
      dx = pix_q[OVL_CH[o]] - x0;
      hit = (pix_q[OVL_CH[o]] >= x0) && (dx < PX_W'(NCHARS << CHAR_SH))
        && (line_q[OVL_CH[o]] >= y0) && (line_q[OVL_CH[o]] < y0 + LN_W'(CHAR_H));
      idx = 5'(dx >> CHAR_SH);
      unique case (ost_q[o])
        OVL_OFF: vis = 1'b0;
        OVL_ON: vis = 1'b1;
        OVL_FAST: vis = ph_fast_q;
        OVL_SLOW: vis = ph_slow_q;
      endcase
      if (reset_i) begin
        ovl_q[o] <= '0;
      end else begin
        ovl_q[o].show <= hit && vis;
        ovl_q[o].char_code <= hit ? txt_q[o][(idx < 5'(NCHARS)) ? idx : 5'h00] : RST_CHAR;
      end
    end
  end

  // read path: data stands in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_i) begin
    logic [31:0] r;
    r = '0;
    for (int c = 0; c < NCHAN; c++) begin
      if (ch_hit[c] && addr_i[3:0] == OFS_FMT_SIG[3:0]) begin
        r = {19'h00000, cfg_q[c].sig, 6'h00, cfg_q[c].fmt};
      end
      if (ch_hit[c] && addr_i[3:0] == OFS_VOFF[3:0]) begin
        r = 32'(cfg_q[c].voff);
      end
      if (ch_hit[c] && addr_i[3:0] == OFS_HOFF[3:0]) begin
        r = 32'(cfg_q[c].hoff);
      end
    end
    for (int o = 0; o < NOVL; o++) begin
      if (ovl_hit[o] && ovl_ofs == OFS_OVL_CTRL[5:0]) begin
        r = {30'h00000000, ost_q[o]};
      end
      if (ovl_hit[o] && ovl_ofs == OFS_OVL_XPOS[5:0]) begin
        r = {25'h0000000, xpos_q[o]};
      end
      if (ovl_hit[o] && ovl_ofs == OFS_OVL_YPOS[5:0]) begin
        r = {25'h0000000, ypos_q[o]};
      end
      for (int k = 0; k < NCHARS; k++) begin
        if (ovl_hit[o] && ovl_ofs == OFS_OVL_TEXT[5:0] + 6'(4 * (k / 4))) begin
          r[8*(k%4) +: 8] = txt_q[o][k];
        end
      end
    end
    if (addr_i == OFS_STAT) begin
      r = {4'h0, line_q[0], 1'b0, ph_slow_q, ph_fast_q, pix_q[0]};
    end
    if (reset_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_i ? r : 32'h00000000;
    end
  end

  // outputs straight from flops
  always_comb begin
    for (int c = 0; c < NCHAN; c++) begin
      tim_o[c].line = line_q[c];
      tim_o[c].pix = pix_q[c];
      tim_o[c].fmt = cfg_q[c].fmt;
      tim_o[c].sig = cfg_q[c].sig;
    end
  end
  assign ovl_o = ovl_q;
  assign ovl_save_o = save_q;
  assign rdata_o = rdata_q;

endmodule

// ==== verification/vto_chk.sv ====
// port assertions for the timing and overlay block
// assumes black 2 offsets stay zero and the frame pin idles low in reset
`timescale 1ns/1ps
module vto_chk import vto_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic frame_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire vto_tim_s [NCHAN-1:0] tim_o,
  input wire vto_ovl_s [NOVL-1:0] ovl_o,
  input wire logic [NOVL-1:0] ovl_save_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // read data appear only after a read
  property p_rd_idle; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  // pixel counter steps by one when no frame load can land
  property p_pix_step;
    !frame_rst_i && !$past(frame_rst_i) && !$past(frame_rst_i, 2) && tim_o[0].pix < PX_W'(NTSC_LINE_CYC - 1)
    |=> tim_o[0].pix == $past(tim_o[0].pix) + 1'b1;
  endproperty
  a_pix_step: assert property (p_pix_step) else $error("pixel counter did not step");
  // last pixel of last line wraps the frame
  property p_line_wrap;
    tim_o[0].fmt == FMT_NTSC && !wr_i && !$past(frame_rst_i) && !$past(frame_rst_i, 2)
    && tim_o[0].pix == PX_W'(NTSC_LINE_CYC - 1)
    && tim_o[0].line == LN_W'(NTSC_CF_LINES - 1) |=> tim_o[0].pix == '0 && tim_o[0].line == '0;
  endproperty
  a_line_wrap: assert property (p_line_wrap) else $error("frame wrap wrong");
  // zero offsets load the origin three clocks after the pin rises
  property p_frame_load; $rose(frame_rst_i) |-> ##3 (tim_o[2].pix == '0 && tim_o[2].line == '0); endproperty
  a_frame_load: assert property (p_frame_load) else $error("frame load wrong");
  property p_save_pulse;
    wr_i && addr_i == OFS_CMD && wdata_i[CMD_SAVE_BIT] |=> ovl_save_o == ($past(wdata_i[CMD_OVL_POS]) ? 2'h2 : 2'h1);
  endproperty
  a_save_pulse: assert property (p_save_pulse) else $error("save pulse wrong");
  property p_save_idle; !$past(wr_i) |-> ovl_save_o == 2'h0; endproperty
  a_save_idle: assert property (p_save_idle) else $error("stray save pulse");
  property p_stat_pix; rd_i && addr_i == OFS_STAT |=> rdata_o[12:0] == $past(tim_o[0].pix); endproperty
  a_stat_pix: assert property (p_stat_pix) else $error("status pixel wrong");
  // overlay never shows before the active picture
  property p_ovl_area;
    ovl_o[0].show |-> $past(tim_o[0].pix) >= PX_W'(ACT_H_START) && $past(tim_o[0].line) >= LN_W'(ACT_V_START);
  endproperty
  a_ovl_area: assert property (p_ovl_area) else $error("overlay outside picture");
endmodule
bind vto_top vto_chk u_chk (.sys_clk_i, .reset_i, .frame_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .tim_o, .ovl_o, .ovl_save_o);

// ==== verification/vto_sink.sv ====
// model of the video equipment watching one overlay output
// assumes clr_i is driven on the same clock edge by the bench
`timescale 1ns/1ps
module vto_sink import vto_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic clr_i,
  input wire vto_ovl_s ovl_i,
  output logic [15:0] show_cnt_o,
  output logic [7:0] first_o,
  output logic [7:0] last_o
);
  // counts visible cycles, keeps first and last glyph seen
  always_ff @(posedge sys_clk_i) begin
    if (clr_i) begin
      show_cnt_o <= 16'h0000;
      first_o <= 8'h00;
      last_o <= 8'h00;
    end else if (ovl_i.show) begin
      show_cnt_o <= show_cnt_o + 16'h0001;
      last_o <= ovl_i.char_code;
      if (show_cnt_o == 16'h0000) begin
        first_o <= ovl_i.char_code;
      end
    end
  end
endmodule

// ==== verification/vto_top_test.sv ====
// self-checking bench for the timing and overlay block
// assumes the strobe register port; blink interval shortened to 8 clocks
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; $display("mismatch at %0t: %h vs %h", $time, g, e); end end
module vto_top_test import vto_pkg::*; ();
  localparam int HS = 8;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic frame_rst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic clr_q = 1'b1;
  logic [31:0] rdata_o;
  logic [31:0] d;
  logic [31:0] st [3];
  vto_tim_s [NCHAN-1:0] tim_o;
  vto_ovl_s [NOVL-1:0] ovl_o;
  logic [NOVL-1:0] ovl_save_o;
  logic [15:0] show_cnt;
  logic [7:0] first_code;
  logic [7:0] last_code;
  logic [15:0] show_cnt1;
  logic [7:0] first_code1;
  logic [7:0] last_code1;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  // offset writes and the readback that must follow (range limits)
  logic [31:0] od [6] = '{32'h20D, 32'h20E, 32'hFFFFFDF3, 32'h1F08, 32'h1F09, 32'hFFFFE0F8};
  logic [31:0] oe [6] = '{32'h20D, 32'h20D, 32'hFFFFFDF3, 32'h1F08, 32'h1F08, 32'hFFFFE0F8};
  // format and signal writes with the {sig, fmt} expected afterwards
  logic [15:0] sd [9] = '{16'h0900, 16'h0802, 16'h0800, 16'h0703, 16'h0701, 16'h0E00, 16'h0200, 16'h0C00, 16'h0C02};
  logic [6:0] sx [9] = '{7'h00, 7'h22, 7'h00, 7'h00, 7'h1D, 7'h38, 7'h38, 7'h38, 7'h32};

  vto_top #(.HALF_SEC(HS)) u_dut (.sys_clk_i, .reset_i, .frame_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .tim_o, .ovl_o, .ovl_save_o);
  vto_sink u_sink (.sys_clk_i, .clr_i(clr_q), .ovl_i(ovl_o[0]), .show_cnt_o(show_cnt), .first_o(first_code),
    .last_o(last_code));
  // second sink watches the bars overlay
  vto_sink u_sink1 (.sys_clk_i, .clr_i(clr_q), .ovl_i(ovl_o[1]), .show_cnt_o(show_cnt1), .first_o(first_code1),
    .last_o(last_code1));

  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // hang guard, far above the expected run
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  // data are taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  // pin pulse, returns just after the counters load
  task automatic pulse();
    @(posedge sys_clk_i);
    clr_q <= 1'b1;
    frame_rst_i <= 1'b1;
    @(posedge sys_clk_i);
    clr_q <= 1'b0;
    frame_rst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  initial begin
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(8'h00, d); `CHK(d, 32'h0B00)
    rd(8'h10, d); `CHK(d, 32'h0)
    rd(8'h40, d); `CHK(d, 32'h0)
    rd(8'hF0, d); `CHK(d, 32'h0)
    for (int i = 0; i < 6; i++) begin
      wr(i < 3 ? 8'h14 : 8'h18, od[i]);
      rd(i < 3 ? 8'h14 : 8'h18, d); `CHK(d[13:0], oe[i][13:0])
    end
    wr(8'hC0, 32'h11);
    rd(8'h14, d); `CHK(d, 32'h0)
    rd(8'h18, d); `CHK(d[13:0], 14'h0)
    for (int i = 0; i < 9; i++) begin
      wr(i < 5 ? 8'h10 : 8'h30, {16'h0, sd[i]});
      `CHK({tim_o[i < 5 ? 1 : 3].sig, tim_o[i < 5 ? 1 : 3].fmt}, sx[i])
    end
    `CHK(tim_o[0].sig, SIG_SMPTE)
    // positive horizontal offset borrows one line
    wr(8'h08, 32'h3);
    pulse(); `CHK({tim_o[0].line, tim_o[0].pix}, {12'h419, 13'h1F05})
    wr(8'h08, 32'hFFFFFB50);
    wr(8'h04, 32'hFFFFFFEB);
    wr(8'h38, 32'hFFFFFB50);
    wr(8'h34, 32'hFFFFFFEB);
    wr(8'h50, 32'h44434241);
    wr(8'h60, 32'h00002051);
    wr(8'h90, 32'h20202058);
    wr(8'h40, 32'h1);
    wr(8'h80, 32'h1);
    pulse(); `CHK({tim_o[3].line, tim_o[3].pix}, {12'h015, 13'h04B0})
    repeat (300) @(posedge sys_clk_i);
    #1;
    `CHK(show_cnt, 16'h0120)
    `CHK(first_code, 8'h41)
    `CHK(last_code, 8'h20)
    `CHK(show_cnt1, 16'h0120)
    `CHK(first_code1, 8'h58)
    `CHK(last_code1, 8'h20)
    // 288 visible cycles hold a whole number of blink periods, so half of them show
    wr(8'h40, 32'h0);
    wr(8'h80, 32'h2);
    pulse();
    repeat (300) @(posedge sys_clk_i);
    #1;
    `CHK(show_cnt, 16'h0000)
    `CHK(show_cnt1, 16'h0090)
    wr(8'h80, 32'h3);
    pulse();
    repeat (300) @(posedge sys_clk_i);
    #1;
    `CHK(show_cnt1, 16'h0090)
    // position percentages: 100 is taken, 101 refused
    wr(8'h44, 32'h64);
    rd(8'h44, d); `CHK(d, 32'h64)
    wr(8'h44, 32'h65);
    rd(8'h44, d); `CHK(d, 32'h64)
    wr(8'h88, 32'h65);
    rd(8'h88, d); `CHK(d, 32'h0)
    wr(8'h88, 32'h32);
    rd(8'h88, d); `CHK(d, 32'h32)
    for (int k = 0; k < 3; k++) begin
      rd(8'hC4, st[k]);
      repeat (HS - 2) @(posedge sys_clk_i);
    end
    `CHK(st[1][13], ~st[0][13])
    `CHK(st[2][13], st[0][13])
    `CHK(st[2][14], ~st[0][14])
    wr(8'hC0, 32'h102);
    `CHK(ovl_save_o, 2'h2)
    wr(8'hC0, 32'h002);
    `CHK(ovl_save_o, 2'h1)
    @(posedge sys_clk_i);
    #1;
    `CHK(ovl_save_o, 2'h0)
    end_of_test();
  end
endmodule
